//--- rtl/rct_pkg.sv
// Purpose: shared constants for the relay closure tally block
// Assumes: 20 MHz system clock, synchronous active-high reset
// Notes: channel code is slot*100 + channel; slots and channels are indexed densely here
package rct_pkg;
    localparam int NUM_SLOTS = 2;
    localparam int CH_PER_SLOT = 40;
    localparam int NUM_CH = NUM_SLOTS * CH_PER_SLOT;
    localparam int CH_W = 7;
    localparam int CODE_W = 10;
    localparam int TALLY_W = 32;
    localparam int MIN_W = 11;
    localparam logic [CODE_W-1:0] SLOT_SCALE = 10'h064;
    localparam logic [MIN_W-1:0] INTERVAL_MIN = 11'h00A;
    localparam logic [MIN_W-1:0] INTERVAL_MAX = 11'h5A0;
    localparam logic [MIN_W-1:0] INTERVAL_DEFAULT = 11'h00F;
    localparam int CLK_HZ = 20_000_000;
    localparam int MINUTE_S = 60;
    localparam int MINUTE_CYCLES = CLK_HZ * MINUTE_S;
    localparam logic [TALLY_W-1:0] TALLY_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_QUERY,
        OP_CLEAR,
        OP_SET_INTERVAL,
        OP_GET_INTERVAL
    } rct_op_e;

    typedef enum {
        ST_LOAD,
        ST_IDLE,
        ST_WALK,
        ST_COMMIT
    } rct_state_e;

    // map slot*100+channel to a dense index; returns NUM_CH when out of range
    function automatic logic [CH_W-1:0] rct_index(input logic [CODE_W-1:0] code);
        logic [CODE_W-1:0] slot;
        logic [CODE_W-1:0] chan;
        slot = code / SLOT_SCALE;
        chan = code % SLOT_SCALE;
        if (slot < 10'h001 || slot > NUM_SLOTS[CODE_W-1:0] || chan < 10'h001 ||
            chan > CH_PER_SLOT[CODE_W-1:0]) begin
            return NUM_CH[CH_W-1:0];
        end
        return CH_W'((slot - 10'h001) * CH_PER_SLOT[CODE_W-1:0] + chan - 10'h001);
    endfunction : rct_index
endpackage : rct_pkg

//--- rtl/rct_minute_timer.sv
// Purpose: counts whole minutes since the last commit and flags interval expiry
// Assumes: restart is a one-cycle pulse from the tally core
// Notes: minute prescaler is a parameter so simulation can shorten it
`timescale 1ns/100ps
module rct_minute_timer
    import rct_pkg::*;
#(
    parameter int MINUTE_CYC = MINUTE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control
    input wire logic restart,
    input wire logic [MIN_W-1:0] interval,
    // status
    output logic expired
);
    logic [31:0] prescale;
    logic [31:0] next_prescale;
    logic [MIN_W-1:0] minutes;
    logic [MIN_W-1:0] next_minutes;
    logic next_expired;

    always_comb begin
        next_prescale = prescale;
        next_minutes = minutes;
        next_expired = 1'b0;
        if (restart) begin
            next_prescale = 32'h0000_0000;
            next_minutes = '0;
        end else if (prescale == 32'(MINUTE_CYC - 1)) begin
            next_prescale = 32'h0000_0000;
            if (minutes + 11'h001 >= interval) begin
                next_expired = 1'b1;
                next_minutes = '0;
            end else begin
                next_minutes = minutes + 11'h001;
            end
        end else begin
            next_prescale = prescale + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prescale <= 32'h0000_0000;
            minutes <= '0;
            expired <= 1'b0;
        end else begin
            prescale <= next_prescale;
            minutes <= next_minutes;
            expired <= next_expired;
        end
    end
endmodule : rct_minute_timer

//--- rtl/rct_tally.sv
// Purpose: per-channel relay closure tallies with periodic nonvolatile commit
// Assumes: relay states are synchronous to CLK; commands come from the remote parser
// Notes: nonvolatile store is a word port; tally commit walks all channels in order
`timescale 1ns/100ps
module rct_tally
    import rct_pkg::*;
#(
    parameter int MINUTE_CYC = MINUTE_CYCLES
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // relay states, one bit per channel, high while closed
    input wire logic [NUM_CH-1:0] RELAY_CLOSED,
    // remote command port: span first..last of channel codes
    input wire logic CMD_VALID,
    input wire logic [2:0] CMD_OP,
    input wire logic [CODE_W-1:0] CMD_FIRST,
    input wire logic [CODE_W-1:0] CMD_LAST,
    input wire logic [MIN_W-1:0] CMD_INTERVAL,
    input wire logic CAL_UNLOCKED,
    // command answers
    output logic CMD_READY,
    output logic RSP_VALID,
    output logic [TALLY_W-1:0] RSP_DATA,
    output logic RSP_DONE,
    output logic CMD_ERROR,
    // nonvolatile store port, one word per cycle
    output logic NV_WRITE,
    output logic NV_READ,
    output logic [CH_W-1:0] NV_ADDR,
    output logic [TALLY_W-1:0] NV_WDATA,
    input wire logic [TALLY_W-1:0] NV_RDATA
);
    rct_state_e state, next_state;
    logic [TALLY_W-1:0] tally [NUM_CH];
    logic [TALLY_W-1:0] next_tally [NUM_CH];
    logic [NUM_CH-1:0] closed_q;
    logic [MIN_W-1:0] interval, next_interval;
    logic [CH_W-1:0] idx, next_idx;
    logic [CH_W-1:0] last, next_last;
    rct_op_e op, next_op;
    logic load_pend, next_load_pend;
    logic next_cmd_ready, next_rsp_valid, next_rsp_done, next_cmd_error;
    logic [TALLY_W-1:0] next_rsp_data;
    logic next_nv_write, next_nv_read;
    logic [CH_W-1:0] next_nv_addr;
    logic [TALLY_W-1:0] next_nv_wdata;
    logic restart, next_restart;
    logic expired;
    logic commit_pend, next_commit_pend;
    logic [CH_W-1:0] first_i, last_i;

    rct_minute_timer #(.MINUTE_CYC(MINUTE_CYC)) u_timer (
        .clk(CLK),
        .reset(RESET),
        .restart(restart),
        .interval(interval),
        .expired(expired)
    );

    assign first_i = rct_index(CMD_FIRST);
    assign last_i = rct_index(CMD_LAST);

    // closure edges; a clear on the same channel in the same cycle loses to the edge
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            next_tally[i] = tally[i];
        end
        if (state == ST_LOAD && load_pend) begin
            next_tally[NV_ADDR] = NV_RDATA;
        end
        if (state == ST_WALK && op == OP_CLEAR) begin
            next_tally[idx] = TALLY_ZERO;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (state != ST_LOAD && RELAY_CLOSED[i] && !closed_q[i]) begin
                next_tally[i] = tally[i] + 32'h0000_0001;
            end
        end
    end

    always_comb begin
        next_state = state;
        next_interval = interval;
        next_idx = idx;
        next_last = last;
        next_op = op;
        next_load_pend = 1'b0;
        next_cmd_ready = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_data = RSP_DATA;
        next_rsp_done = 1'b0;
        next_cmd_error = 1'b0;
        next_nv_write = 1'b0;
        next_nv_read = 1'b0;
        next_nv_addr = NV_ADDR;
        next_nv_wdata = NV_WDATA;
        next_restart = 1'b0;
        // an expiry seen while busy is held, so the timed commit is never lost; set wins
        next_commit_pend = expired || (commit_pend && state != ST_COMMIT);
        case (state)
            ST_LOAD: begin
                if (load_pend && NV_ADDR == CH_W'(NUM_CH - 1)) begin
                    next_state = ST_IDLE;
                    next_restart = 1'b1;
                    next_cmd_ready = 1'b1;
                end else begin
                    next_nv_read = 1'b1;
                    next_load_pend = 1'b1;
                    next_nv_addr = load_pend ? NV_ADDR + 7'h01 : NV_ADDR;
                end
            end
            ST_IDLE: begin
                next_cmd_ready = 1'b1;
                // a command seen with ready high is always taken; the commit waits a turn
                if (CMD_VALID && CMD_READY) begin
                    next_op = rct_op_e'(CMD_OP);
                    next_idx = first_i;
                    next_last = last_i;
                    case (rct_op_e'(CMD_OP))
                        OP_SET_INTERVAL: begin
                            if (CMD_INTERVAL >= INTERVAL_MIN &&
                                CMD_INTERVAL <= INTERVAL_MAX) begin
                                next_interval = CMD_INTERVAL;
                            end else begin
                                next_cmd_error = 1'b1;
                            end
                            next_rsp_done = 1'b1;
                        end
                        OP_GET_INTERVAL: begin
                            next_rsp_valid = 1'b1;
                            next_rsp_data = TALLY_W'(interval);
                            next_rsp_done = 1'b1;
                        end
                        OP_QUERY, OP_CLEAR: begin
                            // bad span or locked clear leaves every tally alone
                            if (first_i == CH_W'(NUM_CH) || last_i == CH_W'(NUM_CH) ||
                                first_i > last_i ||
                                (rct_op_e'(CMD_OP) == OP_CLEAR && !CAL_UNLOCKED)) begin
                                next_cmd_error = 1'b1;
                                next_rsp_done = 1'b1;
                            end else begin
                                next_state = ST_WALK;
                                next_cmd_ready = 1'b0;
                            end
                        end
                        default: begin
                            next_cmd_error = 1'b1;
                            next_rsp_done = 1'b1;
                        end
                    endcase
                end else if (expired || commit_pend) begin
                    next_state = ST_COMMIT;
                    next_op = OP_NONE;
                    next_idx = '0;
                    next_cmd_ready = 1'b0;
                end
            end
            ST_WALK: begin
                if (op == OP_QUERY) begin
                    next_rsp_valid = 1'b1;
                    next_rsp_data = tally[idx];
                end
                if (idx == last) begin
                    if (op == OP_QUERY) begin
                        next_state = ST_COMMIT;
                        next_idx = '0;
                    end else begin
                        next_state = ST_IDLE;
                        next_rsp_done = 1'b1;
                        next_cmd_ready = 1'b1;
                    end
                end else begin
                    next_idx = idx + 7'h01;
                end
            end
            ST_COMMIT: begin
                next_nv_write = 1'b1;
                next_nv_addr = idx;
                next_nv_wdata = tally[idx];
                if (idx == CH_W'(NUM_CH - 1)) begin
                    next_state = ST_IDLE;
                    next_restart = 1'b1;
                    next_rsp_done = (op == OP_QUERY);
                end else begin
                    next_idx = idx + 7'h01;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state <= ST_LOAD;
            interval <= INTERVAL_DEFAULT;
            idx <= '0;
            last <= '0;
            op <= OP_NONE;
            load_pend <= 1'b0;
            closed_q <= '0;
            CMD_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_DATA <= TALLY_ZERO;
            RSP_DONE <= 1'b0;
            CMD_ERROR <= 1'b0;
            NV_WRITE <= 1'b0;
            NV_READ <= 1'b0;
            NV_ADDR <= '0;
            NV_WDATA <= TALLY_ZERO;
            restart <= 1'b0;
            commit_pend <= 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
                tally[i] <= TALLY_ZERO;
            end
        end else begin
            state <= next_state;
            interval <= next_interval;
            idx <= next_idx;
            last <= next_last;
            op <= next_op;
            load_pend <= next_load_pend;
            closed_q <= RELAY_CLOSED;
            CMD_READY <= next_cmd_ready;
            RSP_VALID <= next_rsp_valid;
            RSP_DATA <= next_rsp_data;
            RSP_DONE <= next_rsp_done;
            CMD_ERROR <= next_cmd_error;
            NV_WRITE <= next_nv_write;
            NV_READ <= next_nv_read;
            NV_ADDR <= next_nv_addr;
            NV_WDATA <= next_nv_wdata;
            restart <= next_restart;
            commit_pend <= next_commit_pend;
            for (int i = 0; i < NUM_CH; i++) begin
                tally[i] <= next_tally[i];
            end
        end
    end
endmodule : rct_tally

//--- verification/rct_tally_props.sv
// Purpose: port assertions for the relay closure tally
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to rct_tally by the bind after the module
`timescale 1ns/100ps
module rct_tally_props
    import rct_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // command side
    input wire logic CMD_VALID,
    input wire logic [2:0] CMD_OP,
    input wire logic [CODE_W-1:0] CMD_FIRST,
    input wire logic [CODE_W-1:0] CMD_LAST,
    input wire logic [MIN_W-1:0] CMD_INTERVAL,
    input wire logic CAL_UNLOCKED,
    // answers and store strobes
    input wire logic CMD_READY,
    input wire logic RSP_VALID,
    input wire logic RSP_DONE,
    input wire logic CMD_ERROR,
    input wire logic NV_WRITE,
    input wire logic NV_READ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence s_take(logic [2:0] op);
        CMD_VALID && CMD_READY && CMD_OP == op;
    endsequence
    sequence s_refused;
        RSP_DONE && CMD_ERROR;
    endsequence
    a_error_has_done: assert property (CMD_ERROR |-> RSP_DONE)
        else $error("error pulse without done");
    a_get_answer: assert property (s_take(3'h4) |=> RSP_VALID && RSP_DONE && !CMD_ERROR)
        else $error("interval query not answered next cycle");
    a_set_too_low: assert property (s_take(3'h3) ##0 CMD_INTERVAL < INTERVAL_MIN |=> s_refused)
        else $error("short interval accepted");
    a_set_too_high: assert property (s_take(3'h3) ##0 CMD_INTERVAL > INTERVAL_MAX |=> s_refused)
        else $error("long interval accepted");
    a_set_in_range: assert property (s_take(3'h3) ##0
        CMD_INTERVAL inside {[INTERVAL_MIN:INTERVAL_MAX]} |=> RSP_DONE && !CMD_ERROR)
        else $error("valid interval refused");
    a_clear_locked: assert property (s_take(3'h2) ##0 !CAL_UNLOCKED |=> s_refused)
        else $error("clear accepted while locked");
    a_query_first: assert property (s_take(3'h1) ##0 CMD_FIRST == 10'h065 &&
        CMD_LAST == 10'h065 |-> ##2 RSP_VALID)
        else $error("query word late");
    a_write_busy: assert property (NV_WRITE |-> !CMD_READY)
        else $error("store written while idle");
    a_read_load: assert property (NV_READ |-> !CMD_READY)
        else $error("store read after load");
endmodule : rct_tally_props

bind rct_tally rct_tally_props u_props (.CLK(CLK), .RESET(RESET), .CMD_VALID(CMD_VALID),
    .CMD_OP(CMD_OP), .CMD_FIRST(CMD_FIRST), .CMD_LAST(CMD_LAST), .CMD_INTERVAL(CMD_INTERVAL),
    .CAL_UNLOCKED(CAL_UNLOCKED), .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID),
    .RSP_DONE(RSP_DONE), .CMD_ERROR(CMD_ERROR), .NV_WRITE(NV_WRITE), .NV_READ(NV_READ));

//--- verification/rct_nv_model.sv
// Purpose: nonvolatile tally store facing the tally core
// Assumes: a read is answered combinationally while its strobe stands
// Notes: idle read data flips each cycle so a stale word never passes
`timescale 1ns/100ps
module rct_nv_model
    import rct_pkg::*;
(
    // clock
    input wire logic clk,
    // store port
    input wire logic rd,
    input wire logic wr,
    input wire logic [CH_W-1:0] addr,
    input wire logic [TALLY_W-1:0] wdata,
    output logic [TALLY_W-1:0] rdata,
    output int writes
);
    logic [TALLY_W-1:0] mem [NUM_CH];
    logic [TALLY_W-1:0] idle_word;
    // the core takes the word at the end of the cycle in which its read strobe stands
    assign rdata = rd ? mem[addr] : idle_word;
    initial begin
        idle_word = 32'h0;
        writes = 0;
        foreach (mem[i]) mem[i] = 32'h100 + 32'(i);
    end
    always @(posedge clk) begin
        if (wr) begin
            mem[addr] <= wdata;
            writes <= writes + 1;
        end
        idle_word <= ~idle_word;
    end
endmodule : rct_nv_model

//--- verification/rct_tally_bench.sv
// Purpose: self-checking bench for the relay closure tally
// Assumes: minute shortened to 20 cycles; store preloaded with 100h+index
// Notes: lists are sent as spans of channel codes
`timescale 1ns/100ps
module rct_tally_bench
    import rct_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [NUM_CH-1:0] relay = '0;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_op = 3'h0;
    logic [CODE_W-1:0] first = 10'h0;
    logic [CODE_W-1:0] last = 10'h0;
    logic [MIN_W-1:0] minutes = 11'h0;
    logic unlocked = 1'b0;
    logic ready, rsp_valid, rsp_done, cmd_error, nv_wr, nv_rd, got_err;
    logic [CH_W-1:0] nv_addr;
    logic [TALLY_W-1:0] rsp_data, nv_wdata, nv_rdata;
    logic [TALLY_W-1:0] words [$];
    int nv_writes;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;

    rct_tally #(.MINUTE_CYC(20)) dut (.CLK(clk), .RESET(reset), .RELAY_CLOSED(relay),
        .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_FIRST(first), .CMD_LAST(last),
        .CMD_INTERVAL(minutes), .CAL_UNLOCKED(unlocked), .CMD_READY(ready),
        .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_DONE(rsp_done), .CMD_ERROR(cmd_error),
        .NV_WRITE(nv_wr), .NV_READ(nv_rd), .NV_ADDR(nv_addr), .NV_WDATA(nv_wdata),
        .NV_RDATA(nv_rdata));
    rct_nv_model nv (.clk(clk), .rd(nv_rd), .wr(nv_wr), .addr(nv_addr), .wdata(nv_wdata),
        .rdata(nv_rdata), .writes(nv_writes));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    // a hung handshake ends here rather than running forever
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails = fails + 1;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // request held until ready is seen high; answers sampled at the falling edge
    task automatic cmd(input logic [2:0] op, input logic [CODE_W-1:0] f,
        input logic [CODE_W-1:0] l, input logic [MIN_W-1:0] m);
        words.delete();
        @(posedge clk);
        #1;
        cmd_op = op;
        first = f;
        last = l;
        minutes = m;
        cmd_valid = 1'b1;
        do @(negedge clk); while (ready !== 1'b1);
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        do begin
            @(negedge clk);
            if (rsp_valid === 1'b1) words.push_back(rsp_data);
        end while (rsp_done !== 1'b1);
        got_err = cmd_error;
        // the last store write stands with done and lands one edge later
        @(negedge clk);
    endtask : cmd

    task automatic span3(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
        cmd(3'h1, 10'h065, 10'h067, 11'h0);
        chk("span words", 32'h3, 32'(words.size()));
        chk("tally 101", a, words[0]);
        chk("tally 102", b, words[1]);
        chk("tally 103", c, words[2]);
    endtask : span3

    task automatic t_load;
        span3(32'h100, 32'h101, 32'h102);
        chk("query commit writes", 32'h50, 32'(nv_writes));
        $display("load test done");
    endtask : t_load

    task automatic t_interval;
        cmd(3'h4, 10'h0, 10'h0, 11'h0);
        chk("default interval", 32'hF, words[0]);
        cmd(3'h3, 10'h0, 10'h0, 11'h009);
        chk("refuse 9", 32'h1, 32'(got_err));
        cmd(3'h3, 10'h0, 10'h0, 11'h5A1);
        chk("refuse 1441", 32'h1, 32'(got_err));
        cmd(3'h5, 10'h0, 10'h0, 11'h0);
        chk("unknown op", 32'h1, 32'(got_err));
        cmd(3'h3, 10'h0, 10'h0, 11'h5A0);
        chk("accept 1440", 32'h0, 32'(got_err));
        cmd(3'h4, 10'h0, 10'h0, 11'h0);
        chk("interval 1440", 32'h5A0, words[0]);
        cmd(3'h3, 10'h0, 10'h0, 11'h00A);
        cmd(3'h4, 10'h0, 10'h0, 11'h0);
        chk("interval 10", 32'hA, words[0]);
        $display("interval test done");
    endtask : t_interval

    task automatic t_count;
        @(posedge clk);
        #1;
        relay[2] = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        relay[2] = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        relay[2] = 1'b1;
        relay[1] = 1'b1;
        repeat (3) @(posedge clk);
        span3(32'h100, 32'h102, 32'h104);
        chk("stored tally", 32'h104, nv.mem[2]);
        $display("count test done");
    endtask : t_count

    task automatic t_clear;
        cmd(3'h2, 10'h066, 10'h067, 11'h0);
        chk("locked clear", 32'h1, 32'(got_err));
        cmd(3'h1, 10'h08D, 10'h08D, 11'h0);
        chk("bad code", 32'h1, 32'(got_err));
        @(posedge clk);
        #1;
        unlocked = 1'b1;
        cmd(3'h2, 10'h066, 10'h067, 11'h0);
        chk("unlocked clear", 32'h0, 32'(got_err));
        @(posedge clk);
        #1;
        unlocked = 1'b0;
        span3(32'h100, 32'h0, 32'h0);
        $display("clear test done");
    endtask : t_clear

    // interval is 10 minutes of 20 cycles, so expiry lands near 200 cycles
    task automatic t_commit;
        int w0;
        cmd(3'h1, 10'h065, 10'h065, 11'h0);
        w0 = nv_writes;
        repeat (150) @(negedge clk);
        chk("early commit", 32'(w0), 32'(nv_writes));
        for (int i = 0; i < 300 && nv_writes < w0 + 80; i++) begin
            @(negedge clk);
        end
        chk("interval commit", 32'(w0 + 80), 32'(nv_writes));
        $display("commit test done");
    endtask : t_commit

    initial begin
        repeat (8) @(posedge clk);
        #1;
        reset = 1'b0;
        t_load();
        t_interval();
        t_count();
        t_clear();
        t_commit();
        conclude();
    end
endmodule : rct_tally_bench
